/* File: verilog/rfp_rail_protect.sv */
// Rail fault protection: strap decode, OC/OV/NV protection, power code
`timescale 1ns/1ps
import rfp_pkg::*;

// Overview of operation
// - Width from band position, period of bands
// - Thresholds from band group for both states
// - Overcurrent threshold from overcurrent strap band
// - Overcurrent latches after 40 us qualification
// - Overcurrent masked during voltage change, soft-start
// - Overcurrent re-enabled 46 us after alert
// - Target above 1 V: trip at target+150 mV
// - Target at most 1 V: trip at 1.35 V
// - Overvoltage forces high gates low, low gates high
// - Overvoltage latches after 0.5 us qualification
// - Overvoltage masked, re-enabled 46 us after alert
// - Below -70 mV after latch: low gates off
// - Above 0 V: back to latch, low gates on
// - Negative protection only after overvoltage latch
// - Feature strap enables system power monitor
// - Power input to 8-bit code at 1Bh
// - Power code readable over serial TARGET_VOLTAGE_CODE port
module rfp_rail_protect
#(
   parameter int OC_QUAL_CYC = RFP_OC_QUAL_CYC,
   parameter int REEN_CYC = RFP_REEN_CYC
)
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Strap ADC codes
   input wire logic [RFP_ADC_W-1:0] i_quick_response_strap,
   input wire logic [RFP_ADC_W-1:0] i_overcurrent_strap,
   input wire logic [RFP_ADC_W-1:0] i_feature_strap,
   // Rail measurements
   input wire logic signed [12:0] i_rail_voltage_sense,
   input wire logic [12:0] i_target_voltage_code,
   input wire logic [9:0] i_rail_current,
   input wire logic [RFP_ADC_W-1:0] i_system_power_input,
   // Voltage change and soft-start status
   input wire logic i_dynamic_voltage_change,
   input wire logic i_change_done_alert,
   // Modulator gate requests
   input wire logic [RFP_PHASES-1:0] i_pwm_high,
   input wire logic [RFP_PHASES-1:0] i_pwm_low,
   // Serial TARGET_VOLTAGE_CODE register port
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_ack,
   // Gate drives
   output logic [RFP_PHASES-1:0] o_high_side_gate,
   output logic [RFP_PHASES-1:0] o_low_side_gate,
   // Decoded settings
   output logic [2:0] o_quick_response_width,
   output logic [5:0] o_qr_full_power_state_mv,
   output logic [5:0] o_qr_reduced_power_state_mv,
   output logic [9:0] o_max_rail_current,
   output logic o_system_power_en,
   // Fault status
   output logic o_overcurrent_trip,
   output logic o_overvoltage_trip,
   output logic o_negative_voltage_trip,
   output logic o_protect_armed
);

   localparam logic [RFP_TMR_W-1:0] OC_CNT = RFP_TMR_W'(OC_QUAL_CYC - 1);
   localparam logic [RFP_TMR_W-1:0] REEN_CNT = RFP_TMR_W'(REEN_CYC - 1);
   localparam logic [RFP_TMR_W-1:0] OV_CNT =
      RFP_TMR_W'(RFP_OV_QUAL_CYC - 1);

   logic straps_done_r;
   logic [RFP_BAND_W-1:0] qr_band_r;
   logic [RFP_BAND_W-1:0] oc_band_r;
   logic [RFP_BAND_W-1:0] feat_band_r;
   logic [RFP_BAND_W-1:0] qr_band;
   logic [2:0] qr_grp;
   rfp_qrw_t qr_width_nxt;
   rfp_qrw_t qr_width_r;
   logic [5:0] qr_ps0_nxt;
   logic [5:0] qr_ps1_nxt;
   logic [5:0] qr_ps0_r;
   logic [5:0] qr_ps1_r;
   logic [9:0] oc_thresh_r;
   logic system_power_input_en_r;
   logic armed_r;
   logic reen_pend_r;
   logic reen_done;
   logic oc_over;
   logic oc_done;
   logic ocp_r;
   logic signed [13:0] ov_limit;
   logic ov_detect;
   logic ov_done;
   rfp_ov_state_t ov_state_r;
   rfp_ov_state_t ov_state_nxt;
   logic [RFP_PHASES-1:0] hs_nxt;
   logic [RFP_PHASES-1:0] ls_nxt;
   logic [RFP_PHASES-1:0] hs_r;
   logic [RFP_PHASES-1:0] ls_r;
   logic [7:0] system_power_input_code_r;
   logic [7:0] rdata_r;
   logic ack_r;

   // Strap capture happens one clock after reset release, so no port
   // value ever enters a flip-flop through the asynchronous reset
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         straps_done_r <= 1'b0;
         qr_band_r <= '0;
         oc_band_r <= '0;
         feat_band_r <= '0;
      end
      else if (!straps_done_r)
      begin
         straps_done_r <= 1'b1;
         qr_band_r <= i_quick_response_strap[RFP_ADC_W-1:RFP_BAND_LSB];
         oc_band_r <= i_overcurrent_strap[RFP_ADC_W-1:RFP_BAND_LSB];
         feat_band_r <= i_feature_strap[RFP_ADC_W-1:RFP_BAND_LSB];
      end
   end

   // Bands above 1.6 V lie outside the table and are clamped to the last
   assign qr_band = (qr_band_r > RFP_BAND_LAST) ? RFP_BAND_LAST : qr_band_r;
   assign qr_grp = qr_band[5:RFP_GRP_LSB];

   always_comb
   begin
      unique case (qr_band[2:0])
         3'h0: qr_width_nxt = RFP_QRW_NA;
         3'h1: qr_width_nxt = RFP_QRW_OFF;
         3'h2: qr_width_nxt = RFP_QRW_222;
         3'h3: qr_width_nxt = RFP_QRW_177;
         3'h4: qr_width_nxt = RFP_QRW_133;
         3'h5: qr_width_nxt = RFP_QRW_88;
         3'h6: qr_width_nxt = RFP_QRW_44;
         3'h7: qr_width_nxt = RFP_QRW_NA;
      endcase
   end

   // Full power threshold steps 5 mV per pair of groups from 15 mV
   always_comb
   begin
      qr_ps0_nxt = RFP_QR_BASE_MV + RFP_QR_STEP_MV * {4'h0, qr_grp[2:1]};
      qr_ps1_nxt = qr_grp[0] ? RFP_QR_PS1_HI_MV : RFP_QR_PS1_LO_MV;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         qr_width_r <= RFP_QRW_NA;
         qr_ps0_r <= RFP_QR_BASE_MV;
         qr_ps1_r <= RFP_QR_PS1_LO_MV;
      end
      else
      begin
         qr_width_r <= qr_width_nxt;
         qr_ps0_r <= qr_ps0_nxt;
         qr_ps1_r <= qr_ps1_nxt;
      end
   end

   // Overcurrent threshold from the strap band
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         oc_thresh_r <= '1;
      else
         oc_thresh_r <= 10'(oc_band_r * RFP_OC_AMPS_PER_BAND);
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         system_power_input_en_r <= 1'b0;
      else
         system_power_input_en_r <= straps_done_r && feat_band_r[RFP_FEAT_SYSTEM_POWER_INPUT_BIT];
   end

   // Protection arming: out of reset the rail is in soft-start, so
   // detection waits for the first completion alert
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         reen_pend_r <= 1'b0;
      else if (i_dynamic_voltage_change)
         reen_pend_r <= 1'b0;
      else if (i_change_done_alert)
         reen_pend_r <= 1'b1;
      else if (reen_done)
         reen_pend_r <= 1'b0;
   end

   rfp_qual_timer
   #(
      .CW(RFP_TMR_W),
      .COUNT(REEN_CNT)
   )
   u_reen_timer
   (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_cond(reen_pend_r),
      .o_done(reen_done)
   );

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         armed_r <= 1'b0;
      else if (i_dynamic_voltage_change)
         armed_r <= 1'b0;
      else if (reen_done)
         armed_r <= 1'b1;
   end

   // Overcurrent qualification
   assign oc_over = armed_r && !i_dynamic_voltage_change && !ocp_r
      && (i_rail_current > oc_thresh_r);

   rfp_qual_timer
   #(
      .CW(RFP_TMR_W),
      .COUNT(OC_CNT)
   )
   u_oc_timer
   (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_cond(oc_over),
      .o_done(oc_done)
   );

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         ocp_r <= 1'b0;
      else if (oc_done)
         ocp_r <= 1'b1;
   end

   // Overvoltage limit: a target of exactly 1 V uses the fixed level
   always_comb
   begin
      if ($signed({1'b0, i_target_voltage_code}) > RFP_ONE_VOLT_MV)
         ov_limit = $signed({1'b0, i_target_voltage_code})
            + 14'(RFP_OV_MARGIN_MV);
      else
         ov_limit = 14'(RFP_OV_FIXED_MV);
   end

   assign ov_detect = armed_r && !i_dynamic_voltage_change
      && (14'(i_rail_voltage_sense) > ov_limit);

   rfp_qual_timer
   #(
      .CW(RFP_TMR_W),
      .COUNT(OV_CNT)
   )
   u_ov_timer
   (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_cond(ov_detect && (ov_state_r == RFP_OV_QUAL)),
      .o_done(ov_done)
   );

   always_comb
   begin
      ov_state_nxt = ov_state_r;
      unique case (ov_state_r)
         RFP_OV_IDLE:
         begin
            if (ov_detect)
               ov_state_nxt = RFP_OV_QUAL;
         end
         RFP_OV_QUAL:
         begin
            if (ov_done)
               ov_state_nxt = RFP_OV_LATCH;
            else if (!ov_detect)
               ov_state_nxt = RFP_OV_IDLE;
         end
         RFP_OV_LATCH:
         begin
            if (i_rail_voltage_sense < RFP_NV_LOW_MV)
               ov_state_nxt = RFP_OV_NEG;
         end
         RFP_OV_NEG:
         begin
            if (i_rail_voltage_sense > RFP_ZERO_MV)
               ov_state_nxt = RFP_OV_LATCH;
         end
      endcase
   end

   // Latch and negative states never lead back to idle
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         ov_state_r <= RFP_OV_IDLE;
      else
         ov_state_r <= ov_state_nxt;
   end

   // Gate override follows the next state so the clamp acts on the
   // edge that sees the fault; an overcurrent trip parks both gates off while the overvoltage sequence is idle
   always_comb
   begin
      hs_nxt = i_pwm_high;
      ls_nxt = i_pwm_low;
      unique case (ov_state_nxt)
         RFP_OV_IDLE:
         begin
            if (ocp_r || oc_done)
            begin
               hs_nxt = '0;
               ls_nxt = '0;
            end
         end
         RFP_OV_QUAL, RFP_OV_LATCH:
         begin
            hs_nxt = '0;
            ls_nxt = '1;
         end
         RFP_OV_NEG:
         begin
            hs_nxt = '0;
            ls_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         hs_r <= '0;
         ls_r <= '0;
      end
      else
      begin
         hs_r <= hs_nxt;
         ls_r <= ls_nxt;
      end
   end

   // 4095 codes at 3.2 V map to FF by dropping the low nibble
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         system_power_input_code_r <= RFP_SYS_POWER_RST;
      else if (system_power_input_en_r)
         system_power_input_code_r <= i_system_power_input[RFP_ADC_W-1:4];
      else
         system_power_input_code_r <= RFP_SYS_POWER_RST;
   end

   // Register read port
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rdata_r <= RFP_UNMAPPED_DATA;
         ack_r <= 1'b0;
      end
      else
      begin
         ack_r <= i_reg_rd;
         if (i_reg_rd)
         begin
            if (i_reg_addr == RFP_ADDR_SYS_POWER)
               rdata_r <= system_power_input_code_r;
            else
               rdata_r <= RFP_UNMAPPED_DATA;
         end
      end
   end

   assign o_reg_rdata = rdata_r;
   assign o_reg_ack = ack_r;
   assign o_high_side_gate = hs_r;
   assign o_low_side_gate = ls_r;
   assign o_quick_response_width = qr_width_r;
   assign o_qr_full_power_state_mv = qr_ps0_r;
   assign o_qr_reduced_power_state_mv = qr_ps1_r;
   assign o_max_rail_current = oc_thresh_r;
   assign o_system_power_en = system_power_input_en_r;
   assign o_overcurrent_trip = ocp_r;
   assign o_overvoltage_trip = (ov_state_r == RFP_OV_LATCH)
      || (ov_state_r == RFP_OV_NEG);
   assign o_negative_voltage_trip = (ov_state_r == RFP_OV_NEG);
   assign o_protect_armed = armed_r;

endmodule

/* File: verilog/rfp_pkg.sv */
// Package of constants and types for the rail fault protection block
package rfp_pkg;

   // Clock rate and timing
   localparam int RFP_CLK_MHZ = 250;
   localparam int RFP_OC_QUAL_NS = 40000;
   localparam int RFP_REEN_NS = 46000;
   localparam int RFP_OV_QUAL_NS = 500;
   // Least times round up to whole cycles
   localparam int RFP_OC_QUAL_CYC = (RFP_OC_QUAL_NS * RFP_CLK_MHZ + 999) / 1000;
   localparam int RFP_REEN_CYC = (RFP_REEN_NS * RFP_CLK_MHZ + 999) / 1000;
   localparam int RFP_OV_QUAL_CYC = (RFP_OV_QUAL_NS * RFP_CLK_MHZ + 999) / 1000;
   localparam int RFP_TMR_W = 14;

   // Analog codes: 12-bit ADC, 3.2 V full scale, about 0.78 mV per LSB
   localparam int RFP_ADC_W = 12;
   // One strap band is 32 LSB, about 25 mV
   localparam int RFP_BAND_LSB = 5;
   localparam int RFP_BAND_W = 7;
   localparam logic [6:0] RFP_BAND_LAST = 7'h3F;
   // Eight bands per threshold group, group is band[5:3]
   localparam int RFP_GRP_LSB = 3;
   localparam logic [5:0] RFP_QR_BASE_MV = 6'h0F;
   localparam logic [5:0] RFP_QR_STEP_MV = 6'h05;
   localparam logic [5:0] RFP_QR_PS1_LO_MV = 6'h0A;
   localparam logic [5:0] RFP_QR_PS1_HI_MV = 6'h0F;

   // Voltages in mV, signed 13-bit
   localparam logic signed [12:0] RFP_OV_MARGIN_MV = 13'sh0096;
   localparam logic signed [12:0] RFP_OV_FIXED_MV = 13'sh0546;
   localparam logic signed [12:0] RFP_ONE_VOLT_MV = 13'sh03E8;
   localparam logic signed [12:0] RFP_NV_LOW_MV = -13'sh0046;
   localparam logic signed [12:0] RFP_ZERO_MV = 13'sh0000;

   // Overcurrent threshold step per strap band, in amps
   localparam logic [9:0] RFP_OC_AMPS_PER_BAND = 10'h004;
   // Feature strap band bit that enables the power monitor
   localparam int RFP_FEAT_SYSTEM_POWER_INPUT_BIT = 0;

   // Register map
   localparam logic [7:0] RFP_ADDR_SYS_POWER = 8'h1B;
   localparam logic [7:0] RFP_SYS_POWER_RST = 8'h00;
   localparam logic [7:0] RFP_UNMAPPED_DATA = 8'h00;

   localparam int RFP_PHASES = 2;

   // Quick-response width codes
   typedef enum logic [2:0]
   {
      RFP_QRW_NA = 3'h0,
      RFP_QRW_OFF = 3'h1,
      RFP_QRW_222 = 3'h2,
      RFP_QRW_177 = 3'h3,
      RFP_QRW_133 = 3'h4,
      RFP_QRW_88 = 3'h5,
      RFP_QRW_44 = 3'h6
   } rfp_qrw_t;

   // Overvoltage sequence, Gray along idle, qualify, latch, negative
   typedef enum logic [1:0]
   {
      RFP_OV_IDLE = 2'b00,
      RFP_OV_QUAL = 2'b01,
      RFP_OV_LATCH = 2'b11,
      RFP_OV_NEG = 2'b10
   } rfp_ov_state_t;

endpackage

/* File: verilog/rfp_qual_timer.sv */
// Qualification timer: flags a condition held for a number of cycles
`timescale 1ns/1ps
module rfp_qual_timer
#(
   parameter int CW = 14,
   parameter logic [CW-1:0] COUNT = '1
)
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Condition and result
   input wire logic i_cond,
   output logic o_done
);

   logic [CW-1:0] cnt_r;

   // Any gap in the condition restarts the count
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         cnt_r <= '0;
      else if (!i_cond)
         cnt_r <= '0;
      else if (cnt_r != COUNT)
         cnt_r <= cnt_r + 1'b1;
   end

   assign o_done = i_cond && (cnt_r == COUNT);

endmodule

/* File: dv/rfp_rail_protect_props.sv */
// Port checker for the rail fault protection block
`timescale 1ns/1ps
module rfp_rail_protect_props
import rfp_pkg::*;
#(
   parameter int OC_QUAL_CYC = 20,
   parameter int REEN_CYC = 30
)
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Inputs watched
   input wire logic [9:0] i_rail_current,
   input wire logic i_dynamic_voltage_change,
   input wire logic i_change_done_alert,
   input wire logic i_reg_rd,
   // Outputs watched
   input wire logic o_reg_ack,
   input wire logic [RFP_PHASES-1:0] o_high_side_gate,
   input wire logic [RFP_PHASES-1:0] o_low_side_gate,
   input wire logic [2:0] o_quick_response_width,
   input wire logic [9:0] o_max_rail_current,
   input wire logic o_system_power_en,
   input wire logic o_overcurrent_trip,
   input wire logic o_overvoltage_trip,
   input wire logic o_negative_voltage_trip,
   input wire logic o_protect_armed
);
   logic [15:0] alert_cnt_r;
   logic [15:0] oc_cnt_r;
   logic [3:0] up_cnt_r;

   // Saturates so a stale alert can never look recent
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         alert_cnt_r <= 16'hFFFF;
      else if (i_change_done_alert)
         alert_cnt_r <= 16'h0000;
      else if (alert_cnt_r != 16'hFFFF)
         alert_cnt_r <= alert_cnt_r + 16'h0001;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         oc_cnt_r <= 16'h0000;
      else if (o_protect_armed && i_rail_current > o_max_rail_current)
         oc_cnt_r <= oc_cnt_r + 16'h0001;
      else
         oc_cnt_r <= 16'h0000;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         up_cnt_r <= 4'h0;
      else if (up_cnt_r != 4'hF)
         up_cnt_r <= up_cnt_r + 4'h1;
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   AST_OV_GATES: assert property ((o_overvoltage_trip &&
      !o_negative_voltage_trip)[*2] |->
      o_high_side_gate == '0 && o_low_side_gate == '1)
      else $error("gates not clamped in overvoltage latch");
   AST_NV_GATES: assert property (o_negative_voltage_trip ##1
      o_negative_voltage_trip |-> o_high_side_gate == '0 &&
      o_low_side_gate == '0)
      else $error("gates not all off in negative protection");
   AST_NV_AFTER_OV: assert property ($rose(o_negative_voltage_trip)
      |-> $past(o_overvoltage_trip))
      else $error("negative protection without overvoltage latch");
   AST_OC_HOLD: assert property (o_overcurrent_trip |=>
      o_overcurrent_trip)
      else $error("overcurrent trip cleared");
   AST_OV_HOLD: assert property ((o_overvoltage_trip ||
      o_negative_voltage_trip) |=>
      (o_overvoltage_trip || o_negative_voltage_trip))
      else $error("overvoltage fault cleared");
   AST_OC_QUAL: assert property ($rose(o_overcurrent_trip) |->
      oc_cnt_r >= OC_QUAL_CYC - 2)
      else $error("overcurrent trip before qualification");
   AST_ARM_MASK: assert property (i_dynamic_voltage_change |=>
      !o_protect_armed)
      else $error("protection armed during voltage change");
   AST_ARM_DELAY: assert property ($rose(o_protect_armed) |->
      alert_cnt_r >= REEN_CYC - 3 && alert_cnt_r <= REEN_CYC + 2)
      else $error("protection armed at wrong delay after alert");
   AST_ACK: assert property (i_reg_rd |-> ##[1:2] o_reg_ack)
      else $error("read not acknowledged");
   AST_STRAP_FIXED: assert property (up_cnt_r == 4'hF |->
      $stable(o_max_rail_current) && $stable(o_quick_response_width)
      && $stable(o_system_power_en))
      else $error("decoded strap setting changed");
endmodule

bind rfp_rail_protect rfp_rail_protect_props #(
   .OC_QUAL_CYC(OC_QUAL_CYC),
   .REEN_CYC(REEN_CYC)
) u_props (
   .i_sys_clk(i_sys_clk),
   .i_rst(i_rst),
   .i_rail_current(i_rail_current),
   .i_dynamic_voltage_change(i_dynamic_voltage_change),
   .i_change_done_alert(i_change_done_alert),
   .i_reg_rd(i_reg_rd),
   .o_reg_ack(o_reg_ack),
   .o_high_side_gate(o_high_side_gate),
   .o_low_side_gate(o_low_side_gate),
   .o_quick_response_width(o_quick_response_width),
   .o_max_rail_current(o_max_rail_current),
   .o_system_power_en(o_system_power_en),
   .o_overcurrent_trip(o_overcurrent_trip),
   .o_overvoltage_trip(o_overvoltage_trip),
   .o_negative_voltage_trip(o_negative_voltage_trip),
   .o_protect_armed(o_protect_armed)
);

/* File: dv/rfp_stage_model.sv */
// Power stage and rail model: sense voltage follows the gate drives
`timescale 1ns/1ps
module rfp_stage_model
import rfp_pkg::*;
(
   // Clock
   input wire logic i_sys_clk,
   // Bench control
   input wire logic i_hold,
   input wire logic signed [12:0] i_set_mv,
   // Gates from the block
   input wire logic [RFP_PHASES-1:0] i_high_side_gate,
   input wire logic [RFP_PHASES-1:0] i_low_side_gate,
   // Sensed rail
   output logic signed [12:0] o_sense_mv
);
   initial o_sense_mv = 13'sh0000;
   // Crude slew, enough to bounce between the two protection limits
   always @(negedge i_sys_clk)
   begin
      if (i_hold)
         o_sense_mv <= i_set_mv;
      else if (i_low_side_gate == '1 && i_high_side_gate == '0)
         o_sense_mv <= o_sense_mv - 13'sh0014;
      else if (i_low_side_gate == '0 && i_high_side_gate == '0)
         o_sense_mv <= o_sense_mv + 13'sh0014;
   end
endmodule

/* File: dv/rfp_rail_protect_tb.sv */
// Testbench for the rail fault protection block
`timescale 1ns/1ps
module rfp_rail_protect_tb;
import rfp_pkg::*;
   localparam int OCQ = 20;
   localparam int REN = 30;
   logic clk = 0, rst = 1, rd = 0, chg = 0, alrt = 0, hold = 1;
   logic [11:0] qs = 12'h000, system_power_input = 12'h000;
   logic [12:0] tgt = 13'h044C;
   logic signed [12:0] set_mv = 13'sh0000, sense;
   logic [9:0] cur = 10'h000, mrc;
   logic [7:0] addr = 8'h00, rdata;
   logic [1:0] pwh = 2'h1, pwl = 2'h2, hg, lg;
   logic [2:0] qw;
   logic [5:0] ps0, ps1;
   logic ack, pen, oct, ovt, nvt, arm;
   int n_mismatch = 0, checks = 0, n, b;

   initial forever #2 clk = ~clk;

   rfp_rail_protect #(.OC_QUAL_CYC(OCQ), .REEN_CYC(REN)) DUT (
      .i_sys_clk(clk), .i_rst(rst), .i_quick_response_strap(qs),
      .i_overcurrent_strap(qs), .i_feature_strap(qs),
      .i_rail_voltage_sense(sense), .i_target_voltage_code(tgt),
      .i_rail_current(cur), .i_system_power_input(system_power_input),
      .i_dynamic_voltage_change(chg), .i_change_done_alert(alrt),
      .i_pwm_high(pwh), .i_pwm_low(pwl), .i_reg_rd(rd),
      .i_reg_addr(addr), .o_reg_rdata(rdata), .o_reg_ack(ack),
      .o_high_side_gate(hg), .o_low_side_gate(lg),
      .o_quick_response_width(qw), .o_qr_full_power_state_mv(ps0),
      .o_qr_reduced_power_state_mv(ps1), .o_max_rail_current(mrc),
      .o_system_power_en(pen), .o_overcurrent_trip(oct),
      .o_overvoltage_trip(ovt), .o_negative_voltage_trip(nvt),
      .o_protect_armed(arm));

   rfp_stage_model u_stage (.i_sys_clk(clk), .i_hold(hold),
      .i_set_mv(set_mv), .i_high_side_gate(hg), .i_low_side_gate(lg),
      .o_sense_mv(sense));

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, g);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask

   // Straps are sampled once, so every setting needs its own reset
   task automatic boot(input int band);
      qs = {band[6:0], 5'h10};
      rst = 1;
      cyc(4);
      rst = 0;
      cyc(4);
   endtask

   task automatic wt(ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v && n < lim)
      begin
         cyc(1);
         n++;
      end
   endtask

   task automatic rdreg(input logic [7:0] a, e);
      addr = a;
      rd = 1;
      cyc(1);
      rd = 0;
      wt(ack, 1'b1, 3);
      chk("ack", 16'h1, ack);
      chk("rdata", e, rdata);
   endtask

   task automatic arm_up;
      alrt = 1;
      cyc(1);
      alrt = 0;
      wt(arm, 1'b1, REN + 10);
      chk("armed", 16'h1, arm);
   endtask

   initial
   begin
      #(5000 * 4);
      n_mismatch++;
      end_sim();
   end

   initial
   begin
      cyc(3);
      chk("rst_trips", 16'h0, {oct, ovt, nvt, arm, hg, lg});
      chk("rst_icc", 16'h3FF, mrc);
      for (b = 0; b < 64; b++)
      begin
         boot(b);
         chk("width", (b % 8 == 7) ? 0 : b % 8, qw);
         chk("ps0", 15 + 5 * b[5:4], ps0);
         chk("ps1", b[3] ? 15 : 10, ps1);
         chk("icc", 4 * b, mrc);
         chk("system_power_input_en", b[0], pen);
      end
      qs = 12'h050;
      cyc(5);
      chk("fixed", {3'h0, 10'd252}, {qw, mrc});
      $display("test strap done");
      boot(1);
      system_power_input = 12'hFFF;
      cyc(3);
      rdreg(8'h1B, 8'hFF);
      system_power_input = 12'h7A5;
      cyc(3);
      rdreg(8'h1B, 8'h7A);
      rdreg(8'h1C, 8'h00);
      boot(2);
      rdreg(8'h1B, 8'h00);
      $display("test power code done");
      boot(5);
      cur = 10'd25;
      cyc(OCQ + 10);
      chk("oc_unarmed", 16'h0, oct);
      cur = 10'd0;
      arm_up();
      cur = 10'd25;
      cyc(OCQ - 5);
      cur = 10'd0;
      cyc(2);
      chk("oc_brief", 16'h0, oct);
      cur = 10'd25;
      wt(oct, 1'b1, OCQ + 10);
      chk("oc_trip", 16'h1, oct);
      chk("oc_delay", 16'h1, n >= OCQ - 3);
      chk("oc_gates", 16'h0, {hg, lg});
      cur = 10'd0;
      chg = 1;
      cyc(3);
      chk("mask", 16'h0, arm);
      chk("oc_held", 16'h1, oct);
      chg = 0;
      $display("test overcurrent done");
      boot(5);
      set_mv = -13'sh0064;
      cyc(3);
      chk("nv_no_ov", 16'h0, nvt);
      set_mv = 13'sh03E8;
      arm_up();
      set_mv = 13'sh04E2;
      cyc(4);
      chk("ov_edge", pwl, lg);
      set_mv = 13'sh04E3;
      cyc(2);
      chk("ov_clamp", 16'h3, {hg, lg});
      set_mv = 13'sh03E8;
      cyc(3);
      chk("ov_drop", {pwh, pwl}, {hg, lg});
      chk("ov_none", 16'h0, ovt);
      tgt = 13'h0384;
      set_mv = 13'sh0546;
      cyc(4);
      chk("ov_fixed_edge", pwl, lg);
      set_mv = 13'sh0547;
      wt(ovt, 1'b1, 140);
      chk("ov_trip", 16'h1, ovt);
      chk("ov_delay", 16'h1, n >= 120);
      hold = 0;
      wt(nvt, 1'b1, 150);
      chk("nv_trip", 16'h0, {hg, lg});
      wt(nvt, 1'b0, 20);
      chk("nv_exit", 16'h3, {hg, lg});
      wt(nvt, 1'b1, 20);
      chk("nv_again", 16'h1, nvt);
      $display("test overvoltage done");
      end_sim();
   end
endmodule
